/* File: logic/ifc_async_inband_flow_char_detect.sv */
// Receive-side flow control and termination character detector, one channel
`timescale 1ns/10ps
module ifc_async_inband_flow_char_detect
    import ifc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_len_ok,
    input  wire logic        rx_parity_err,
    output logic             fifo_wr_valid,
    output logic      [7:0]  fifo_wr_data,
    output logic             tx_paused,
    output logic             block_end,
    output logic             irq
);

    // Software-visible state
    logic [31:0]      flow_chars_ff;
    logic             term_en_ff;
    logic [7:0]       term_char_ff;
    logic [5:0]       chan_cfg_ff;
    logic [IRQ_W-1:0] irq_en_ff;
    logic [31:0]      rdata_ff;
    logic [31:0]      nxt_rdata;

    // Receive path state
    logic             fifo_valid_ff;
    logic [7:0]       fifo_data_ff;
    logic             paused_ff;
    logic             nxt_paused;
    logic             block_end_ff;

    // Decoded fields
    logic [7:0]       resume_char;
    logic [7:0]       pause_char;
    logic [7:0]       resume_char_mask;
    logic [7:0]       pause_char_mask;
    logic [1:0]       char_length_field;
    logic             parity_check_en;
    logic             inband_flow_enable;
    ifc_mode_type     chan_mode;
    logic [7:0]       sig_mask;
    logic             framed;
    logic             resume_hit;
    logic             pause_hit;
    logic             term_mode;
    logic             term_hit;
    logic             wr_flow;
    logic             wr_term;
    logic             wr_cfg;
    logic             wr_clr;
    logic             wr_en;

    ifc_irq_if ibus ();

    // Register field slices of the flow character word
    assign resume_char      = flow_chars_ff[FC_RESUME_LSB +: 8];
    assign pause_char       = flow_chars_ff[FC_PAUSE_LSB +: 8];
    assign resume_char_mask = flow_chars_ff[FC_RESUME_MASK_LSB +: 8];
    assign pause_char_mask  = flow_chars_ff[FC_PAUSE_MASK_LSB +: 8];

    // Channel configuration fields
    assign char_length_field  = chan_cfg_ff[CFG_LEN_LSB +: 2];
    assign parity_check_en    = chan_cfg_ff[CFG_PARITY_BIT];
    assign inband_flow_enable = chan_cfg_ff[CFG_FLOW_BIT];
    assign chan_mode          = ifc_mode_type'(chan_cfg_ff[CFG_MODE_LSB +: 2]);

    // Write strobes per register; the bus never waits, so decode is plain
    assign wr_flow = reg_wr && (reg_addr == OFF_FLOW_CHARS);
    assign wr_term = reg_wr && (reg_addr == OFF_TERM_CTRL);
    assign wr_cfg  = reg_wr && (reg_addr == OFF_CHAN_CFG);
    assign wr_clr  = reg_wr && (reg_addr == OFF_IRQ_CLEAR);
    assign wr_en   = reg_wr && (reg_addr == OFF_IRQ_ENABLE);

    // Flow character register, stored whole
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            flow_chars_ff <= RST_FLOW_CHARS;
        else if (wr_flow)
            flow_chars_ff <= reg_wdata;
    end

    // Termination register keeps only its enable and character bits
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            term_en_ff   <= 1'b0;
            term_char_ff <= RST_TERM_CHAR;
        end
        else if (wr_term)
        begin
            term_en_ff   <= reg_wdata[TC_ENABLE_BIT];
            term_char_ff <= reg_wdata[TC_CHAR_LSB +: 8];
        end
    end

    // Channel configuration: length, parity check, flow enable, mode
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            chan_cfg_ff <= RST_CHAN_CFG;
        else if (wr_cfg)
            chan_cfg_ff <= reg_wdata[5:0];
    end

    // Interrupt enable register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_en_ff <= RST_IRQ;
        else if (wr_en)
            irq_en_ff <= reg_wdata[IRQ_W-1:0];
    end

    // Read mux; unmapped and write-only offsets read as zero
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFF_FLOW_CHARS: nxt_rdata = flow_chars_ff;
                OFF_TERM_CTRL:
                begin
                    nxt_rdata[TC_ENABLE_BIT]    = term_en_ff;
                    nxt_rdata[TC_CHAR_LSB +: 8] = term_char_ff;
                end
                OFF_CHAN_CFG:   nxt_rdata[5:0] = chan_cfg_ff;
                OFF_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = ibus.status;
                OFF_IRQ_ENABLE: nxt_rdata[IRQ_W-1:0] = irq_en_ff;
                OFF_FLOW_STATE: nxt_rdata[0] = paused_ff;
                default:        nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdata_ff <= 32'h00000000;
        else
            rdata_ff <= nxt_rdata;
    end

    // Received bits above the programmed length never take part in a compare
    assign sig_mask = ifc_len_mask(char_length_field);

    // Only correctly framed characters in async mode are flow candidates
    assign framed = rx_valid && rx_len_ok && !(parity_check_en && rx_parity_err)
                    && (chan_mode == IFC_MODE_ASYNC);

    // Resume character compare
    ifc_char_match u_resume_match
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .rx_char  (rx_data),
        .ref_char (resume_char),
        .ref_mask (resume_char_mask),
        .len_mask (sig_mask),
        .framed   (framed),
        .hit      (resume_hit)
    );

    // Pause character compare
    ifc_char_match u_pause_match
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .rx_char  (rx_data),
        .ref_char (pause_char),
        .ref_mask (pause_char_mask),
        .len_mask (sig_mask),
        .framed   (framed),
        .hit      (pause_hit)
    );

    // Termination compare masks only the received byte; stray upper bits in the stored character block a match
    assign term_mode = (chan_mode == IFC_MODE_ASYNC) || (chan_mode == IFC_MODE_BISYNC);
    assign term_hit  = rx_valid && term_en_ff && term_mode
                       && ((rx_data & sig_mask) == term_char_ff);

    // Every character is forwarded, flow characters included
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fifo_valid_ff <= 1'b0;
            fifo_data_ff  <= 8'h00;
        end
        else
        begin
            fifo_valid_ff <= rx_valid;
            if (rx_valid)
                fifo_data_ff <= rx_data;
        end
    end

    // Transmitter flow state; pause wins if one character hits both
    always_comb
    begin
        nxt_paused = paused_ff;
        if (!inband_flow_enable)
            nxt_paused = 1'b0;
        else if (pause_hit)
            nxt_paused = 1'b1;
        else if (resume_hit)
            nxt_paused = 1'b0;
    end

    // Flow state register; disabling flow control frees the transmitter
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            paused_ff <= 1'b0;
        else
            paused_ff <= nxt_paused;
    end

    // End-of-block pulse, one cycle, aligned with the forwarded character
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            block_end_ff <= 1'b0;
        else
            block_end_ff <= term_hit;
    end

    // Events into the sticky status block; clears come from software
    assign ibus.evt[IRQ_RESUME_BIT] = resume_hit;
    assign ibus.evt[IRQ_PAUSE_BIT]  = pause_hit;
    assign ibus.evt[IRQ_TERM_BIT]   = term_hit;
    assign ibus.clr = wr_clr ? reg_wdata[IRQ_W-1:0] : RST_IRQ;
    assign ibus.en  = irq_en_ff;

    ifc_irq_ctrl u_irq
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ibus    (ibus.ctrl)
    );

    // Outputs
    assign reg_rdata     = rdata_ff;
    assign fifo_wr_valid = fifo_valid_ff;
    assign fifo_wr_data  = fifo_data_ff;
    assign tx_paused     = paused_ff;
    assign block_end     = block_end_ff;
    assign irq           = ibus.irq;

    // Checks on the receive path
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_pause_seen;
        pause_hit && inband_flow_enable;
    endsequence

    sequence s_resume_seen;
        resume_hit && !pause_hit && inband_flow_enable;
    endsequence

    sequence s_resume_equal;
        framed && (((rx_data ^ resume_char) & ~resume_char_mask & sig_mask) == 8'h00);
    endsequence

    sequence s_pause_equal;
        framed && (((rx_data ^ pause_char) & ~pause_char_mask & sig_mask) == 8'h00);
    endsequence

    a_resume_compare: assert property (s_resume_equal |-> resume_hit)
        else $error("resume character not recognised");
    a_pause_compare: assert property (s_pause_equal |-> pause_hit)
        else $error("pause character not recognised");
    a_fifo_pass: assert property (rx_valid |=>
        fifo_wr_valid && fifo_wr_data == $past(rx_data))
        else $error("received character not forwarded");
    a_pause_state: assert property (s_pause_seen |=> tx_paused ##1
        (tx_paused || !$past(inband_flow_enable) || $past(resume_hit)))
        else $error("pause character did not stop the transmitter");
    a_resume_state: assert property (s_resume_seen |=> !tx_paused)
        else $error("resume character did not free the transmitter");
    a_resume_status: assert property (resume_hit |=> ibus.status[IRQ_RESUME_BIT])
        else $error("resume status not set");
    a_term_pulse: assert property (term_hit |=>
        block_end ##1 (block_end == $past(term_hit)))
        else $error("termination pulse wrong");
    a_term_disabled: assert property (!term_en_ff && !wr_term |=> !block_end)
        else $error("end of block while detection is off");
    a_term_read: assert property (reg_rd && reg_addr == OFF_TERM_CTRL |=>
        reg_rdata[31:16] == 16'h0000 && reg_rdata[14:8] == 7'h00)
        else $error("termination register reserved bits not zero");
    a_flow_layout: assert property (reg_rd && reg_addr == OFF_FLOW_CHARS && !reg_wr
        |=> reg_rdata[FC_RESUME_LSB +: 8] == $past(resume_char))
        else $error("flow register layout wrong");

    // Refused characters and modes must leave state alone; a write to enables can race
    a_flow_off_free: assert property (
        !inband_flow_enable |=> !tx_paused)
        else $error("transmitter held while in-band flow control is off");
    a_unframed_hold: assert property (
        rx_valid && !rx_len_ok && inband_flow_enable |=> $stable(tx_paused))
        else $error("badly framed character changed the flow state");
    a_flow_char_kept: assert property (
        (resume_hit || pause_hit) |=> fifo_wr_valid && fifo_wr_data == $past(rx_data))
        else $error("flow character not forwarded");
    a_pause_irq: assert property (
        pause_hit && irq_en_ff[IRQ_PAUSE_BIT] && !wr_en |=> irq)
        else $error("enabled pause event did not raise the interrupt");
    a_resume_irq: assert property (
        resume_hit && irq_en_ff[IRQ_RESUME_BIT] && !wr_en |=> irq)
        else $error("enabled resume event did not raise the interrupt");
    a_term_hdlc_off: assert property (
        chan_mode == IFC_MODE_HDLC |=> !block_end)
        else $error("end of block outside the character modes");
    a_term_upper_bits: assert property (
        (term_char_ff & ~sig_mask) != 8'h00 |=> !block_end)
        else $error("termination matched with bits above the length");

endmodule

/* File: logic/ifc_pkg.sv */
// Shared constants and types for the in-band flow character detector
package ifc_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_FLOW_CHARS = 12'h144;
    localparam logic [11:0] OFF_TERM_CTRL  = 12'h148;
    localparam logic [11:0] OFF_CHAN_CFG   = 12'h160;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h164;
    localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h168;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h16C;
    localparam logic [11:0] OFF_FLOW_STATE = 12'h170;

    // Field positions
    localparam int FC_RESUME_LSB      = 24;
    localparam int FC_PAUSE_LSB       = 16;
    localparam int FC_RESUME_MASK_LSB = 8;
    localparam int FC_PAUSE_MASK_LSB  = 0;
    localparam int TC_ENABLE_BIT      = 15;
    localparam int TC_CHAR_LSB        = 0;
    localparam int CFG_LEN_LSB        = 0;
    localparam int CFG_PARITY_BIT     = 2;
    localparam int CFG_FLOW_BIT       = 3;
    localparam int CFG_MODE_LSB       = 4;
    localparam int IRQ_RESUME_BIT     = 0;
    localparam int IRQ_PAUSE_BIT      = 1;
    localparam int IRQ_TERM_BIT       = 2;
    localparam int IRQ_W              = 3;

    // Reset values
    localparam logic [31:0] RST_FLOW_CHARS = 32'h00000000;
    localparam logic [7:0]  RST_TERM_CHAR  = 8'h00;
    localparam logic [5:0]  RST_CHAN_CFG   = 6'h00;
    localparam logic [2:0]  RST_IRQ        = 3'h0;

    // Protocol modes of the channel
    typedef enum logic [1:0] {
        IFC_MODE_ASYNC  = 2'h0,
        IFC_MODE_BISYNC = 2'h1,
        IFC_MODE_HDLC   = 2'h2
    } ifc_mode_type;

    // Significant bits of a character, LSB first, for lengths 5 to 8
    function automatic logic [7:0] ifc_len_mask(input logic [1:0] len_code);
        logic [7:0] m;
        m = 8'hFF;
        unique case (len_code)
            2'h0: m = 8'h1F;
            2'h1: m = 8'h3F;
            2'h2: m = 8'h7F;
            2'h3: m = 8'hFF;
        endcase
        return m;
    endfunction

endpackage

/* File: logic/ifc_irq_if.sv */
// Event and interrupt signals between the detector core and its status block
`timescale 1ns/10ps
interface ifc_irq_if;
    logic [2:0] evt;
    logic [2:0] clr;
    logic [2:0] en;
    logic [2:0] status;
    logic       irq;

    modport core (output evt, output clr, output en, input status, input irq);
    modport ctrl (input evt, input clr, input en, output status, output irq);
endinterface

/* File: logic/ifc_char_match.sv */
// Masked, length-limited compare of a received character against one value
`timescale 1ns/10ps
module ifc_char_match
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] rx_char,
    input  wire logic [7:0] ref_char,
    input  wire logic [7:0] ref_mask,
    input  wire logic [7:0] len_mask,
    input  wire logic       framed,
    output logic            hit
);
    // Masked positions and bits above the length always match
    assign hit = framed && (((rx_char ^ ref_char) & ~ref_mask & len_mask) == 8'h00);

    a_mask_all_ones: assert property (@(posedge clk) disable iff (sys_rst)
        (framed && ref_mask == 8'hFF) |-> hit)
        else $error("fully masked character did not match");
    a_unframed_miss: assert property (@(posedge clk) disable iff (sys_rst)
        !framed |-> !hit)
        else $error("badly framed character matched");
endmodule

/* File: logic/ifc_irq_ctrl.sv */
// Sticky interrupt status with enable gating onto one level output
`timescale 1ns/10ps
module ifc_irq_ctrl
    import ifc_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    ifc_irq_if.ctrl   ibus
);
    logic [IRQ_W-1:0] status_ff;

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            status_ff <= RST_IRQ;
        else
            status_ff <= (status_ff & ~ibus.clr) | ibus.evt;
    end

    assign ibus.status = status_ff;
    assign ibus.irq    = |(status_ff & ibus.en);

    a_irq_raise: assert property (@(posedge clk) disable iff (sys_rst)
        (ibus.evt[IRQ_RESUME_BIT] && ibus.en[IRQ_RESUME_BIT]) ##1 ibus.en[IRQ_RESUME_BIT]
        |-> ibus.irq)
        else $error("enabled event did not raise the interrupt");
    a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (ibus.evt[IRQ_PAUSE_BIT] && ibus.clr[IRQ_PAUSE_BIT]) |=> ibus.status[IRQ_PAUSE_BIT])
        else $error("event lost against a simultaneous clear");
endmodule

/* File: tb/ifc_remote_station.sv */
// Behavioural model of the remote serial station feeding received characters
`timescale 1ns/10ps
module ifc_remote_station
(
    input  wire logic       clk,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_len_ok,
    output logic            rx_parity_err
);
    // Line starts idle with no character offered
    initial
    begin
        rx_valid      = 1'b0;
        rx_data       = 8'h00;
        rx_len_ok     = 1'b0;
        rx_parity_err = 1'b0;
    end

    // One character per call; framing and parity outcome travel with it
    task automatic send(input logic [7:0] ch, input logic len_ok, input logic par_err);
        @(posedge clk);
        rx_valid      <= 1'b1;
        rx_data       <= ch;
        rx_len_ok     <= len_ok;
        rx_parity_err <= par_err;
        @(posedge clk);
        // Qualifiers are meaningless after the strobe, so show garbage, not stale data
        rx_valid      <= 1'b0;
        rx_data       <= ~ch;
        rx_len_ok     <= ~len_ok;
        rx_parity_err <= ~par_err;
    endtask
endmodule

/* File: tb/ifc_async_inband_flow_char_detect_tb.sv */
// Self-checking bench for the flow and termination character detector
`timescale 1ns/10ps
module ifc_async_inband_flow_char_detect_tb
    import ifc_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_len_ok;
    logic        rx_parity_err;
    logic        fifo_wr_valid;
    logic [7:0]  fifo_wr_data;
    logic        tx_paused;
    logic        block_end;
    logic        irq;
    int          bad_count;
    int          compares;
    int          cycles;

    ifc_async_inband_flow_char_detect u_ifc_async_inband_flow_char_detect (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_len_ok(rx_len_ok), .rx_parity_err(rx_parity_err),
        .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
        .tx_paused(tx_paused), .block_end(block_end), .irq(irq));

    ifc_remote_station u_ifc_remote_station (
        .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_len_ok(rx_len_ok),
        .rx_parity_err(rx_parity_err));

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Cut a hung run short; ceiling far above the roughly 150 cycles expected
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares = compares + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        chk_reg({24'h000000, got}, {24'h000000, exp}, m);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_reg({31'h00000000, got}, {31'h00000000, exp}, m);
    endtask

    // Single-cycle write strobe, no wait state
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp, "read data");
    endtask

    // Receive one character and judge every reaction one cycle later
    task automatic rx_chk(input logic [7:0] d, input logic ok, input logic pe,
                          input logic p, input logic q, input logic e);
        u_ifc_remote_station.send(d, ok, pe);
        #1;
        chk_bit(fifo_wr_valid, 1'b1, "fifo strobe");
        chk_byte(fifo_wr_data, d, "fifo data");
        chk_bit(tx_paused, p, "pause state");
        chk_bit(irq, q, "irq level");
        chk_bit(block_end, e, "block end");
        @(posedge clk);
        #1;
        chk_bit(fifo_wr_valid, 1'b0, "fifo strobe width");
        chk_bit(block_end, 1'b0, "block end width");
    endtask

    task automatic t_regs();
        rd_chk(OFF_FLOW_CHARS, 32'h00000000);
        rd_chk(OFF_TERM_CTRL, 32'h00000000);
        wr(OFF_FLOW_CHARS, 32'hA55AC33C);
        rd_chk(OFF_FLOW_CHARS, 32'hA55AC33C);
        wr(OFF_TERM_CTRL, 32'hFFFFFFFF);
        rd_chk(OFF_TERM_CTRL, 32'h000080FF);
        wr(12'h1F0, 32'hFFFFFFFF);
        rd_chk(12'h1F0, 32'h00000000);
        rd_chk(OFF_IRQ_CLEAR, 32'h00000000);
        $display("test registers done");
    endtask

    task automatic t_flow();
        wr(OFF_TERM_CTRL, 32'h00000000);
        wr(OFF_FLOW_CHARS, 32'h11130000);
        wr(OFF_CHAN_CFG, 32'h0000000B);
        wr(OFF_IRQ_ENABLE, 32'h00000003);
        rx_chk(8'h13, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        rd_chk(OFF_IRQ_STATUS, 32'h00000002);
        rd_chk(OFF_FLOW_STATE, 32'h00000001);
        wr(OFF_IRQ_CLEAR, 32'h00000002);
        chk_bit(irq, 1'b0, "irq after clear");
        rx_chk(8'h11, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        rd_chk(OFF_IRQ_STATUS, 32'h00000001);
        wr(OFF_IRQ_CLEAR, 32'h00000007);
        $display("test flow done");
    endtask

    task automatic t_mask();
        // Five-bit characters; pause value has bit 2 masked, interrupts off
        wr(OFF_CHAN_CFG, 32'h00000008);
        wr(OFF_FLOW_CHARS, 32'h11130004);
        wr(OFF_IRQ_ENABLE, 32'h00000000);
        rx_chk(8'hF3, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_chk(8'hF1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_chk(8'h17, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_chk(8'h15, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        rd_chk(OFF_IRQ_STATUS, 32'h00000003);
        wr(OFF_IRQ_CLEAR, 32'h00000007);
        $display("test masks done");
    endtask

    task automatic t_frame();
        wr(OFF_FLOW_CHARS, 32'h11130000);
        wr(OFF_IRQ_ENABLE, 32'h00000003);
        wr(OFF_CHAN_CFG, 32'h0000000F);
        rx_chk(8'h11, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_chk(8'h11, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(OFF_CHAN_CFG, 32'h0000000B);
        rx_chk(8'h11, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        wr(OFF_IRQ_CLEAR, 32'h00000007);
        wr(OFF_CHAN_CFG, 32'h00000003);
        rx_chk(8'h13, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(OFF_IRQ_CLEAR, 32'h00000007);
        wr(OFF_CHAN_CFG, 32'h0000001B);
        rx_chk(8'h13, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("test framing done");
    endtask

    task automatic t_term();
        wr(OFF_FLOW_CHARS, 32'h11130000);
        wr(OFF_CHAN_CFG, 32'h0000000B);
        wr(OFF_IRQ_ENABLE, 32'h00000004);
        wr(OFF_TERM_CTRL, 32'h0000800D);
        rx_chk(8'h0D, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        rd_chk(OFF_IRQ_STATUS, 32'h00000004);
        wr(OFF_IRQ_CLEAR, 32'h00000007);
        rx_chk(8'h0C, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(OFF_TERM_CTRL, 32'h0000000D);
        rx_chk(8'h0D, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        // Seven-bit characters: a stored upper bit can never match
        wr(OFF_CHAN_CFG, 32'h0000000A);
        wr(OFF_TERM_CTRL, 32'h0000808D);
        rx_chk(8'h8D, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(OFF_TERM_CTRL, 32'h0000800D);
        rx_chk(8'h8D, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        wr(OFF_IRQ_CLEAR, 32'h00000007);
        wr(OFF_CHAN_CFG, 32'h0000002B);
        rx_chk(8'h0D, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("test termination done");
    endtask

    // Main sequence: reset for 16 cycles, then every scenario in turn
    initial
    begin
        bad_count = 0;
        compares  = 0;
        cycles    = 0;
        sys_rst   = 1'b1;
        reg_addr  = 12'h000;
        reg_wdata = 32'h00000000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_flow();
        t_mask();
        t_frame();
        t_term();
        summarize();
    end
endmodule
